// ---- design/actuator_cfg.svh ----
// Constants of the actuator register map: addresses, codes, field positions, timing.
// Assumes a frame decoder outside that hands over one register or bit per request.
//
// Function
// - Register n sits at protocol address n-1
// - All entries reachable via holding-register functions
// - Function codes 3 and 6 always supported
// - Codes 4, 16 reach same table; code 2 reads flag bits
// - Bit reads from 1664 return flags word bits
// - Setpoint is target in hundredths of percent
// - Override code selects fixed target instead
// - Command starts service action, then self-clears
// - Service registers persist in non-volatile storage
// - No setpoint/override write 120 s fires watchdog
// - Fault reset keeps flag bits 0 and 4
`ifndef ACTUATOR_CFG_SVH
`define ACTUATOR_CFG_SVH

`define ADDR_SETPOINT 16'h0000
`define ADDR_OVERRIDE 16'h0001
`define ADDR_ACTION 16'h0002
`define ADDR_CATEGORY 16'h0003
`define ADDR_POS_PCT 16'h0004
`define ADDR_POS_ABS 16'h0005
`define ADDR_FLOW_PCT 16'h0006
`define ADDR_FLOW_ABS 16'h0007
`define ADDR_SENSOR 16'h0008
`define ADDR_SERIAL1 16'h0064
`define ADDR_SERIAL2 16'h0065
`define ADDR_SERIAL4 16'h0066
`define ADDR_FW_REV 16'h0067
`define ADDR_FLAGS 16'h0068
`define ADDR_LOWER 16'h0069
`define ADDR_UPPER 16'h006a
`define ADDR_SENSOR_KIND 16'h006b
`define ADDR_FAIL_POS 16'h006c
`define ADDR_BIT_BASE 16'h0680
`define ADDR_BIT_LAST 16'h068f

`define FC_READ_BITS 8'h02
`define FC_READ_HOLD 8'h03
`define FC_READ_INPUT 8'h04
`define FC_WRITE_ONE 8'h06
`define FC_WRITE_MANY 8'h10

`define EXC_FUNCTION 8'h01
`define EXC_ADDRESS 8'h02
`define EXC_VALUE 8'h03

`define OVR_NONE 16'h0000
`define OVR_OPEN 16'h0001
`define OVR_CLOSE 16'h0002
`define OVR_MIN 16'h0003
`define OVR_MAX 16'h0005

`define ACT_NONE 16'h0000
`define ACT_CLEAR_FAULTS 16'h0004
`define ACT_LAST 16'h0004

`define FULL_SCALE 16'h2710
`define FLAG_KEEP_MASK 8'h11
`define FLAG_ACTIVITY_BIT 8
`define FLAG_GEAR_BIT 9
`define FLAG_WDOG_BIT 10

`define CLK_HZ 100000000
`define TICK_TIME_US 1000
`define TICK_CYCLES (`CLK_HZ / 1000000 * `TICK_TIME_US)
`define WDOG_TIME_S 120
`define WDOG_TICKS (`WDOG_TIME_S * 1000000 / `TICK_TIME_US)

`endif

// ---- design/actuator_pkg.sv ----
// Types shared by the actuator register map.
// Assumes the constants header is included alongside.
package actuator_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic {PH_BOOT, PH_RUN} phase_e;
endpackage

// ---- design/modbus_actuator_register_map.sv ----
// Register map and command decoding of a bus-controlled damper actuator.
// Assumes a frame decoder that passes one word or bit per request and sends the answer.
`timescale 1ns/10ps
`include "actuator_cfg.svh"

module modbus_actuator_register_map #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
    parameter int unsigned WDOG_TICKS = `WDOG_TICKS,
    parameter logic [15:0] SERIAL_ONE = 16'h0001,
    parameter logic [15:0] SERIAL_TWO = 16'h0002,
    parameter logic [15:0] SERIAL_FOUR = 16'h0004,
    parameter logic [15:0] FW_REV = 16'h0064
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic rsp_exc,
    output logic [7:0] rsp_code,
    output logic [15:0] rsp_data,
    input wire logic [15:0] unit_category,
    input wire logic [15:0] position_percent,
    input wire logic [15:0] position_absolute,
    input wire logic [15:0] flow_percent,
    input wire logic [15:0] flow_absolute,
    input wire logic [15:0] sensor_reading,
    input wire logic [7:0] fault_event,
    input wire logic activity_busy,
    input wire logic gear_released,
    input wire logic [15:0] nv_lower,
    input wire logic [15:0] nv_upper,
    input wire logic [15:0] nv_sensor_kind,
    input wire logic [15:0] nv_fail_pos,
    output logic nv_wr_en,
    output logic [1:0] nv_wr_sel,
    output logic [15:0] nv_wr_data,
    output logic [15:0] target_pos,
    output logic svc_start,
    output logic [15:0] svc_code
);
    // Serial numbers and firmware revision above are arbitrary values.
    actuator_pkg::phase_e phase_reg;
    actuator_pkg::word_t setpoint_reg, override_reg, action_reg;
    actuator_pkg::word_t lower_reg, upper_reg, sensor_kind_reg, fail_pos_reg;
    logic [7:0] fault_reg;
    logic wdog_fired_reg;
    logic [31:0] tick_cnt_reg, wdog_cnt_reg;
    actuator_pkg::word_t read_word;

    wire run = (phase_reg == actuator_pkg::PH_RUN);
    wire fc_read = (req_func == `FC_READ_HOLD) || (req_func == `FC_READ_INPUT);
    wire fc_write = (req_func == `FC_WRITE_ONE) || (req_func == `FC_WRITE_MANY);
    wire fc_bits = (req_func == `FC_READ_BITS);
    wire addr_lo = (req_addr <= `ADDR_SENSOR);
    wire addr_hi = (req_addr >= `ADDR_SERIAL1) && (req_addr <= `ADDR_FAIL_POS);
    wire addr_wr = (req_addr <= `ADDR_ACTION) || ((req_addr >= `ADDR_LOWER) && addr_hi);
    wire addr_bit = (req_addr >= `ADDR_BIT_BASE) && (req_addr <= `ADDR_BIT_LAST);
    wire ovr_ok = (req_wdata == `OVR_NONE) || (req_wdata == `OVR_OPEN) || (req_wdata == `OVR_CLOSE)
        || (req_wdata == `OVR_MIN) || (req_wdata == `OVR_MAX);
    wire val_ok = (req_addr == `ADDR_OVERRIDE) ? ovr_ok
        : (req_addr == `ADDR_ACTION) ? (req_wdata <= `ACT_LAST) : 1'b1;
    wire fc_ok = fc_read || fc_write || fc_bits;
    wire adr_ok = fc_bits ? addr_bit : fc_write ? addr_wr : (addr_lo || addr_hi);
    // Exception requests touch nothing: writes only happen through wr_hit
    wire wr_hit = req_valid && run && fc_write && addr_wr && val_ok;
    wire wr_sp = wr_hit && (req_addr == `ADDR_SETPOINT);
    wire wr_ovr = wr_hit && (req_addr == `ADDR_OVERRIDE);
    wire wr_act = wr_hit && (req_addr == `ADDR_ACTION);
    wire wr_nv = wr_hit && (req_addr >= `ADDR_LOWER);
    wire [1:0] nv_sel = 2'(req_addr - `ADDR_LOWER);
    wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
    wire wdog_kick = wr_sp || wr_ovr;
    wire wdog_due = tick && (wdog_cnt_reg == WDOG_TICKS - 1) && !wdog_kick;
    wire clear_faults = (action_reg == `ACT_CLEAR_FAULTS);
    wire [15:0] flags_word = {5'h00, wdog_fired_reg, gear_released, activity_busy, fault_reg};
    wire [7:0] exc_code = !fc_ok ? `EXC_FUNCTION : !adr_ok ? `EXC_ADDRESS : `EXC_VALUE;
    wire exc_hit = !fc_ok || !adr_ok || (fc_write && !val_ok);

    always_comb begin
        case (req_addr)
            `ADDR_SETPOINT: read_word = setpoint_reg;
            `ADDR_OVERRIDE: read_word = override_reg;
            `ADDR_ACTION: read_word = action_reg;
            `ADDR_CATEGORY: read_word = unit_category;
            `ADDR_POS_PCT: read_word = position_percent;
            `ADDR_POS_ABS: read_word = position_absolute;
            `ADDR_FLOW_PCT: read_word = flow_percent;
            `ADDR_FLOW_ABS: read_word = flow_absolute;
            `ADDR_SENSOR: read_word = sensor_reading;
            `ADDR_SERIAL1: read_word = SERIAL_ONE;
            `ADDR_SERIAL2: read_word = SERIAL_TWO;
            `ADDR_SERIAL4: read_word = SERIAL_FOUR;
            `ADDR_FW_REV: read_word = FW_REV;
            `ADDR_FLAGS: read_word = flags_word;
            `ADDR_LOWER: read_word = lower_reg;
            `ADDR_UPPER: read_word = upper_reg;
            `ADDR_SENSOR_KIND: read_word = sensor_kind_reg;
            `ADDR_FAIL_POS: read_word = fail_pos_reg;
            default: read_word = 16'h0000;
        endcase
    end

    // Bit reads fetch one flag; the framer packs bits for multi-bit requests
    wire [15:0] rsp_word = fc_bits ? {15'h0000, flags_word[req_addr[3:0]]}
        : fc_read ? read_word : req_wdata;

    // Target: watchdog position beats override, override beats setpoint
    wire [15:0] target_next = wdog_fired_reg ? fail_pos_reg
        : (override_reg == `OVR_OPEN) ? `FULL_SCALE
        : (override_reg == `OVR_CLOSE) ? 16'h0000
        : (override_reg == `OVR_MIN) ? lower_reg
        : (override_reg == `OVR_MAX) ? upper_reg
        : setpoint_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= actuator_pkg::PH_BOOT;
        end else begin
            phase_reg <= actuator_pkg::PH_RUN;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setpoint_reg <= 16'h0000;
            override_reg <= `OVR_NONE;
        end else begin
            if (wr_sp) setpoint_reg <= req_wdata;
            if (wr_ovr) override_reg <= req_wdata;
        end
    end

    // Action is visible for one cycle, then drops back to none by itself
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            action_reg <= `ACT_NONE;
            svc_start <= 1'b0;
            svc_code <= `ACT_NONE;
        end else begin
            action_reg <= wr_act ? req_wdata : `ACT_NONE;
            svc_start <= (action_reg != `ACT_NONE);
            svc_code <= action_reg;
        end
    end

    // Service registers come from storage once after reset, and each write goes back
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lower_reg <= 16'h0000;
            upper_reg <= `FULL_SCALE;
            sensor_kind_reg <= 16'h0000;
            fail_pos_reg <= 16'h0000;
        end else if (!run) begin
            lower_reg <= nv_lower;
            upper_reg <= nv_upper;
            sensor_kind_reg <= nv_sensor_kind;
            fail_pos_reg <= nv_fail_pos;
        end else if (wr_nv) begin
            case (nv_sel)
                2'h0: lower_reg <= req_wdata;
                2'h1: upper_reg <= req_wdata;
                2'h2: sensor_kind_reg <= req_wdata;
                default: fail_pos_reg <= req_wdata;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_wr_en <= 1'b0;
            nv_wr_sel <= 2'h0;
            nv_wr_data <= 16'h0000;
        end else begin
            nv_wr_en <= wr_nv;
            nv_wr_sel <= nv_sel;
            nv_wr_data <= req_wdata;
        end
    end

    // New fault events win over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_reg <= 8'h00;
        end else begin
            fault_reg <= fault_event | (clear_faults ? (fault_reg & `FLAG_KEEP_MASK) : fault_reg);
        end
    end

    // Millisecond tick keeps the long watchdog count narrow and shortenable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_reg <= 32'h0000_0000;
            wdog_cnt_reg <= 32'h0000_0000;
            wdog_fired_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
            if (wdog_kick) begin
                wdog_cnt_reg <= 32'h0000_0000;
            end else if (tick && !wdog_fired_reg) begin
                wdog_cnt_reg <= wdog_due ? 32'h0000_0000 : wdog_cnt_reg + 32'h0000_0001;
            end
            if (wdog_kick) begin
                wdog_fired_reg <= 1'b0;
            end else if (wdog_due) begin
                wdog_fired_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            target_pos <= 16'h0000;
        end else begin
            target_pos <= target_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid <= 1'b0;
            rsp_exc <= 1'b0;
            rsp_code <= 8'h00;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= req_valid && run;
            rsp_exc <= exc_hit;
            rsp_code <= exc_hit ? exc_code : req_func;
            rsp_data <= exc_hit ? 16'h0000 : rsp_word;
        end
    end

    property p_read_index;
        @(posedge clk) disable iff (!rst_b)
        (req_valid && run && req_func == `FC_READ_HOLD && req_addr == `ADDR_POS_PCT)
        |=> (rsp_valid && !rsp_exc && rsp_data == $past(position_percent));
    endproperty
    a_read_index: assert property (p_read_index) else $error("Address 4 did not return register 5");

    property p_flags_by_hold;
        @(posedge clk) disable iff (!rst_b)
        (req_valid && run && fc_read && req_addr == `ADDR_FLAGS) |=> (!rsp_exc && rsp_data == $past(flags_word));
    endproperty
    a_flags_by_hold: assert property (p_flags_by_hold) else $error("Flags word not reachable as register");

    property p_write_single;
        @(posedge clk) disable iff (!rst_b)
        (req_valid && run && req_func == `FC_WRITE_ONE && req_addr == `ADDR_SETPOINT)
        |=> (setpoint_reg == $past(req_wdata)) ##1 (target_pos == $past(setpoint_reg)
            || $past(override_reg) != `OVR_NONE || $past(wdog_fired_reg));
    endproperty
    a_write_single: assert property (p_write_single) else $error("Setpoint write did not reach target");

    property p_input_read;
        @(posedge clk) disable iff (!rst_b)
        (req_valid && run && req_func == `FC_READ_INPUT && req_addr == `ADDR_SENSOR)
        |=> (rsp_data == $past(sensor_reading) && rsp_code == `FC_READ_INPUT);
    endproperty
    a_input_read: assert property (p_input_read) else $error("Input register read missed table");

    property p_bit_read;
        @(posedge clk) disable iff (!rst_b)
        (req_valid && run && fc_bits && addr_bit)
        |=> (!rsp_exc && rsp_data[0] == $past(flags_word[req_addr[3:0]]));
    endproperty
    a_bit_read: assert property (p_bit_read) else $error("Bit read returned wrong flag");

    property p_override_open;
        @(posedge clk) disable iff (!rst_b)
        (override_reg == `OVR_OPEN && !wdog_fired_reg) |=> (target_pos == `FULL_SCALE);
    endproperty
    a_override_open: assert property (p_override_open) else $error("Open override not full scale");

    property p_action_clears;
        @(posedge clk) disable iff (!rst_b)
        (action_reg != `ACT_NONE && !wr_act) |=> (action_reg == `ACT_NONE && svc_start && svc_code == $past(action_reg));
    endproperty
    a_action_clears: assert property (p_action_clears) else $error("Service action did not start and clear");

    property p_nv_write;
        @(posedge clk) disable iff (!rst_b)
        (wr_hit && req_addr == `ADDR_UPPER) |=> (nv_wr_en && nv_wr_sel == 2'h1 && nv_wr_data == upper_reg);
    endproperty
    a_nv_write: assert property (p_nv_write) else $error("Service write not sent to storage");

    property p_wdog_fire;
        @(posedge clk) disable iff (!rst_b)
        wdog_due |=> (wdog_fired_reg && flags_word[`FLAG_WDOG_BIT]) ##1 (target_pos == fail_pos_reg || wdog_kick
            || $past(wdog_kick));
    endproperty
    a_wdog_fire: assert property (p_wdog_fire) else $error("Watchdog did not take fail position");

    property p_keep_bits;
        @(posedge clk) disable iff (!rst_b)
        (clear_faults && fault_reg[0] && fault_reg[4]) |=> (fault_reg[0] && fault_reg[4]);
    endproperty
    a_keep_bits: assert property (p_keep_bits) else $error("Bit 0 or 4 cleared by fault reset");

    property p_exc_stable;
        @(posedge clk) disable iff (!rst_b)
        (req_valid && run && exc_hit) |=> (rsp_exc && $stable(setpoint_reg) && $stable(override_reg) && !nv_wr_en);
    endproperty
    a_exc_stable: assert property (p_exc_stable) else $error("Exception request changed state");

    c_fault_clear: cover property (@(posedge clk) disable iff (!rst_b) clear_faults && fault_reg != 8'h00);
    c_wdog: cover property (@(posedge clk) disable iff (!rst_b) wdog_due);
    c_bad_func: cover property (@(posedge clk) disable iff (!rst_b) req_valid && run && !fc_ok);
    c_multi_write: cover property (@(posedge clk) disable iff (!rst_b) wr_hit && req_func == `FC_WRITE_MANY);
endmodule

// ---- tb/modbus_master_model.sv ----
// Bus master model: one register or bit request per call, as the framer hands them over.
// Assumes the map answers on the same edge that takes a request.
`timescale 1ns/10ps
`include "actuator_cfg.svh"

module modbus_master_model (
    input wire logic clk,
    output logic req_valid,
    output logic [7:0] req_func,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_exc,
    input wire logic [7:0] rsp_code,
    input wire logic [15:0] rsp_data
);
    initial begin
        req_valid = 1'b0;
        req_func = 8'h00;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
    end

    // Register number from 1, or a bit index for bit reads
    task automatic access(input logic [7:0] f, input logic [15:0] n, input logic [15:0] d,
                          output logic ok, output logic ex, output logic [7:0] c, output logic [15:0] q);
        logic [15:0] a;
        if (f == `FC_READ_BITS) begin
            a = `ADDR_BIT_BASE + n;
        end else begin
            a = n - 16'h0001;
        end
        @(negedge clk);
        req_valid = 1'b1;
        req_func = f;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        @(negedge clk);
        ok = rsp_valid;
        ex = rsp_exc;
        c = rsp_code;
        q = rsp_data;
        // Released lines show the inverse, so a stale value never looks valid
        req_valid = 1'b0;
        req_func = ~f;
        req_addr = ~a;
        req_wdata = ~d;
    endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the actuator register map.
// Assumes the master model drives requests; live, fault and stored inputs come from here.
`timescale 1ns/10ps
`include "actuator_cfg.svh"

module testbench;
    logic clk, rst_b, req_valid, rsp_valid, rsp_exc, activity_busy, gear_released;
    logic nv_wr_en, svc_start;
    logic [7:0] req_func, rsp_code, fault_event;
    logic [15:0] req_addr, req_wdata, rsp_data, target_pos, svc_code, nv_wr_data;
    logic [15:0] pos_pct, pos_abs, flow_pct, flow_abs, sensor, category;
    logic [15:0] nv_lower, nv_upper, nv_kind, nv_fail, svc_seen, nv_data_seen;
    logic [15:0] svc_hits = 16'h0000;
    logic [1:0] nv_wr_sel, nv_sel_seen;
    int bad_count, tests_run, i;
    logic [15:0] ovr_code [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0000};
    logic [15:0] ovr_exp [5] = '{`FULL_SCALE, 16'h0000, 16'h07d0, 16'h2328, 16'h1388};
    logic [15:0] flags_boot = 16'h0313;

    // Short watchdog counts keep the run brief: 4 x 5 = 20 cycles
    modbus_actuator_register_map #(.TICK_CYCLES(4), .WDOG_TICKS(5), .SERIAL_ONE(16'h5a5a))
        u_modbus_actuator_register_map (
        .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_code(rsp_code),
        .rsp_data(rsp_data), .unit_category(category), .position_percent(pos_pct),
        .position_absolute(pos_abs), .flow_percent(flow_pct), .flow_absolute(flow_abs),
        .sensor_reading(sensor), .fault_event(fault_event), .activity_busy(activity_busy),
        .gear_released(gear_released), .nv_lower(nv_lower), .nv_upper(nv_upper),
        .nv_sensor_kind(nv_kind), .nv_fail_pos(nv_fail), .nv_wr_en(nv_wr_en), .nv_wr_sel(nv_wr_sel),
        .nv_wr_data(nv_wr_data), .target_pos(target_pos), .svc_start(svc_start), .svc_code(svc_code)
    );

    modbus_master_model u_modbus_master_model (
        .clk(clk), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_code(rsp_code),
        .rsp_data(rsp_data)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulses are caught here, so their exact cycle need not be guessed
    always @(posedge clk) begin
        if (svc_start === 1'b1) begin
            svc_seen <= svc_code;
            svc_hits <= svc_hits + 16'h0001;
        end
        if (nv_wr_en === 1'b1) begin
            nv_sel_seen <= nv_wr_sel;
            nv_data_seen <= nv_wr_data;
        end
    end

    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic op(input logic [7:0] f, input logic [15:0] n, input logic [15:0] d,
                      input logic ex, input logic [7:0] c, input logic [15:0] q);
        logic ok, rex;
        logic [7:0] rc;
        logic [15:0] rq;
        u_modbus_master_model.access(f, n, d, ok, rex, rc, rq);
        chk("rsp_valid", 16'h0001, {15'h0000, ok});
        chk("rsp_exc", {15'h0000, ex}, {15'h0000, rex});
        chk("rsp_code", {8'h00, c}, {8'h00, rc});
        chk("rsp_data", q, rq);
    endtask

    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        rst_b = 1'b0;
        bad_count = 0;
        tests_run = 0;
        {category, pos_pct, pos_abs} = {16'h0002, 16'h1a2b, 16'h002d};
        {flow_pct, flow_abs, sensor} = {16'h0bb8, 16'h0190, 16'h04d2};
        {fault_event, activity_busy, gear_released} = {8'h00, 1'b0, 1'b0};
        {nv_lower, nv_upper, nv_kind, nv_fail} = {16'h07d0, 16'h2328, 16'h0003, 16'h0e10};
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        // First edge is the boot load; stored inputs change on a falling edge after it
        repeat (2) @(negedge clk);
        // Stored values must come from the boot load only
        {nv_lower, nv_upper, nv_kind, nv_fail} = 64'h0000_0000_0000_0000;
        op(`FC_READ_HOLD, 16'h006a, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h07d0);
        op(`FC_READ_HOLD, 16'h006c, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h0003);
        op(`FC_READ_HOLD, 16'h0065, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h5a5a);
        op(`FC_WRITE_ONE, 16'h0001, 16'h1388, 1'b0, `FC_WRITE_ONE, 16'h1388);
        settle();
        chk("target_pos", 16'h1388, target_pos);
        op(`FC_READ_INPUT, 16'h0001, 16'h0000, 1'b0, `FC_READ_INPUT, 16'h1388);
        op(`FC_READ_HOLD, 16'h0005, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h1a2b);
        op(`FC_READ_INPUT, 16'h0009, 16'h0000, 1'b0, `FC_READ_INPUT, 16'h04d2);
        for (i = 0; i < 5; i++) begin
            op(`FC_WRITE_ONE, 16'h0002, ovr_code[i], 1'b0, `FC_WRITE_ONE, ovr_code[i]);
            settle();
            chk("target_pos", ovr_exp[i], target_pos);
        end
        op(`FC_WRITE_MANY, 16'h006b, 16'h2000, 1'b0, `FC_WRITE_MANY, 16'h2000);
        settle();
        chk("nv_wr_sel", 16'h0001, {14'h0000, nv_sel_seen});
        chk("nv_wr_data", 16'h2000, nv_data_seen);
        op(`FC_READ_HOLD, 16'h006b, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h2000);
        op(`FC_WRITE_ONE, 16'h0001, 16'h0fa0, 1'b0, `FC_WRITE_ONE, 16'h0fa0);
        op(8'h05, 16'h0001, 16'h0001, 1'b1, `EXC_FUNCTION, 16'h0000);
        op(`FC_WRITE_ONE, 16'h0002, 16'h0004, 1'b1, `EXC_VALUE, 16'h0000);
        op(`FC_WRITE_ONE, 16'h0003, 16'h0005, 1'b1, `EXC_VALUE, 16'h0000);
        op(`FC_WRITE_ONE, 16'h0004, 16'h0001, 1'b1, `EXC_ADDRESS, 16'h0000);
        op(`FC_READ_HOLD, 16'h000a, 16'h0000, 1'b1, `EXC_ADDRESS, 16'h0000);
        op(`FC_READ_BITS, 16'h0010, 16'h0000, 1'b1, `EXC_ADDRESS, 16'h0000);
        op(`FC_READ_HOLD, 16'h0001, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h0fa0);
        chk("svc_hits", 16'h0000, svc_hits);
        @(negedge clk);
        fault_event = 8'h13;
        {activity_busy, gear_released} = 2'b11;
        @(negedge clk);
        fault_event = 8'h00;
        op(`FC_WRITE_ONE, 16'h0002, 16'h0000, 1'b0, `FC_WRITE_ONE, 16'h0000);
        op(`FC_READ_HOLD, 16'h0069, 16'h0000, 1'b0, `FC_READ_HOLD, flags_boot);
        for (i = 0; i < 10; i++) begin
            op(`FC_READ_BITS, i[15:0], 16'h0000, 1'b0, `FC_READ_BITS, {15'h0000, flags_boot[i]});
        end
        for (i = 1; i < 5; i++) begin
            op(`FC_WRITE_ONE, 16'h0003, i[15:0], 1'b0, `FC_WRITE_ONE, i[15:0]);
            settle();
            chk("svc_code", i[15:0], svc_seen);
            chk("svc_hits", i[15:0], svc_hits);
        end
        op(`FC_READ_HOLD, 16'h0003, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h0000);
        op(`FC_WRITE_ONE, 16'h0001, 16'h0fa0, 1'b0, `FC_WRITE_ONE, 16'h0fa0);
        op(`FC_READ_HOLD, 16'h0069, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h0311);
        // No refresh for twice the watchdog span
        repeat (40) @(negedge clk);
        op(`FC_READ_HOLD, 16'h0069, 16'h0000, 1'b0, `FC_READ_HOLD, 16'h0711);
        chk("target_pos", 16'h0e10, target_pos);
        op(`FC_WRITE_ONE, 16'h0002, 16'h0000, 1'b0, `FC_WRITE_ONE, 16'h0000);
        settle();
        chk("target_pos", 16'h0fa0, target_pos);
        print_verdict();
    end
endmodule
